//--- include/icc_pkg.sv
// Package of constants and types for the injector command block
package icc_pkg;
  localparam int unsigned NUM_CH           = 4;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned MS_CYCLES        = CLK_HZ / 1000;
  localparam int unsigned TIME_W           = 16;
  localparam int unsigned COUNT_W          = 16;
  localparam int unsigned RATE_W           = 12;
  localparam int unsigned SEQ_DEPTH        = 8;
  localparam int unsigned SEQ_AW           = 3;
  localparam int unsigned ANGLE_W          = 12;
  localparam logic [3:0]  ALL_CH_OFF       = 4'h0;
  localparam logic [2:0]  SEL_DISABLED     = 3'h0;
  // Register offsets
  localparam logic [7:0] REG_CONTROL       = 8'h00;
  localparam logic [7:0] REG_STATUS        = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS    = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK      = 8'h0C;
  localparam logic [7:0] REG_CH_ENABLE     = 8'h10;
  localparam logic [7:0] REG_SP_CTRL       = 8'h14;
  localparam logic [7:0] REG_CAL_COUNT     = 8'h18;
  localparam logic [7:0] REG_CAL_WIDTH     = 8'h1C;
  localparam logic [7:0] REG_CAL_PERIOD    = 8'h20;
  localparam logic [7:0] REG_SHORT_LIMIT   = 8'h24;
  localparam logic [7:0] REG_CRANK_REF     = 8'h28;
  localparam logic [7:0] REG_SEQ_CTRL      = 8'h2C;
  localparam logic [7:0] REG_SEQ_DATA      = 8'h30;
  // Control and single-pulse register field positions
  localparam int unsigned CTL_ENABLE_BIT   = 0;
  localparam int unsigned CTL_MODE_LSB     = 1;
  localparam int unsigned CTL_EDGE_BIT     = 3;
  localparam int unsigned CTL_OPEN_SUP_BIT = 4;
  localparam int unsigned CTL_CLEAR_BIT    = 5;
  localparam int unsigned CTL_INV_LSB      = 8;
  localparam int unsigned SP_TRIG_BIT      = 31;
  localparam int unsigned SP_SEL_LSB       = 16;
  // Interrupt status bits
  localparam int unsigned IRQ_SHORT_BIT    = 0;
  localparam int unsigned IRQ_OPEN_BIT     = 1;
  localparam int unsigned IRQ_SEQ_BIT      = 2;
  localparam int unsigned IRQ_W            = 3;
  // Reset values
  localparam logic [31:0] CONTROL_RST      = 32'h0000_0000;
  localparam logic [15:0] SP_TIME_RST      = 16'h0001;

  typedef enum logic [1:0] {
    ICC_MODE_DIRECT = 2'b00,
    ICC_MODE_CAL    = 2'b01,
    ICC_MODE_TRAIN  = 2'b10,
    ICC_MODE_ANGLE  = 2'b11
  } icc_mode_t;

  typedef enum logic [1:0] {
    ICC_SEQ_IDLE  = 2'b00,
    ICC_SEQ_WAIT  = 2'b01,
    ICC_SEQ_PULSE = 2'b11,
    ICC_SEQ_GAP   = 2'b10
  } icc_seq_t;
endpackage

//--- hw/icc_seq_mem.sv
// Small pulse-sequence memory with registered read data
`timescale 1ns/10ps
module icc_seq_mem (
  input  wire logic                      core_clk,
  input  wire logic                      wr_en,
  input  wire logic [icc_pkg::SEQ_AW-1:0] wr_addr,
  input  wire logic [31:0]               wr_data,
  input  wire logic [icc_pkg::SEQ_AW-1:0] rd_addr,
  output logic      [31:0]               rd_data
);
  logic [31:0] mem [icc_pkg::SEQ_DEPTH];

  // Write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge core_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

//--- hw/icc_short_det.sv
// Per-channel short detector from current rise rate, with latched flag
`timescale 1ns/10ps
module icc_short_det (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       sample_en,
  input  wire logic [icc_pkg::RATE_W-1:0] current,
  input  wire logic [icc_pkg::RATE_W-1:0] rate_limit,
  input  wire logic                       clear,
  output logic                            short_flag
);
  logic [icc_pkg::RATE_W-1:0] prev_current;
  logic [icc_pkg::RATE_W-1:0] rise;
  logic                       trip;

  // Rise over one sample interval, zero when falling
  always_comb begin
    rise = (current > prev_current) ? current - prev_current : '0;
    trip = sample_en && (rise > rate_limit);
  end

  // Previous sample
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_current <= '0;
    end else if (sample_en) begin
      prev_current <= current;
    end
  end

  // Latched flag; a trip wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      short_flag <= 1'b0;
    end else if (trip) begin
      short_flag <= 1'b1; // (R14)
    end else if (clear) begin
      short_flag <= 1'b0; // (R18)
    end
  end
endmodule

//--- hw/icc_top.sv
// Injector channel command source, single pulse and fault control
// How it works
// (R1) Present flag only with enable on, module inserted and externally powered.
// (R2) Controller talks to the module only once enabled, inserted and powered.
// (R3) One command-source mode drives all four injector channels, never lowside.
// (R4) Direct mode: each channel follows its input for exactly as long.
// (R5) Direct mode: per-input inversion chooses which level switches on.
// (R6) Calibration: configured count of pulses, configured width, configured period.
// (R7) Calibration delivers nothing when more than one channel is enabled.
// (R8) Triggered mode: sequence starts on selected rising or falling trigger edge.
// (R9) Angle mode: each pulse starts when crank angle meets reference-relative angle.
// (R10) Single-pulse trigger gives one pulse of programmed milliseconds to chosen channel.
// (R11) Single-pulse trigger clears itself so one activation gives one pulse.
// (R12) Channel select value zero disables single pulses entirely.
// (R13) Fault-clear strobe clears every latched short flag together.
// (R14) Short flagged per channel when current rise rate exceeds its limit.
// (R15) A short shuts down only its own channel.
// (R16) Open-fault suppression keeps open indicators from being raised.
// (R17) Open faults never stop pulses; indicator updates at each pulse end.
// (R18) Shut-down channel stays off with flag set until fault clear.
`timescale 1ns/10ps
module icc_top (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        slot_occupied,
  input  wire logic        ext_power_ok,
  input  wire logic [3:0]  direct_in,
  input  wire logic        train_trigger_in,
  input  wire logic        crank_event_in,
  input  wire logic [11:0] crank_angle,
  input  wire logic        current_valid,
  input  wire logic [47:0] channel_current,
  input  wire logic [3:0]  reached_open_level,
  output logic      [3:0]  injector_cmd,
  output logic      [3:0]  short_circuit_flags,
  output logic      [3:0]  open_fault_flags,
  output logic             module_present_flag,
  output logic             module_link_en,
  output logic             irq
);
  logic [31:0] control;
  logic [3:0]  chan_enable;
  logic [15:0] single_pulse_duration;
  logic [2:0]  single_pulse_channel_select;
  logic        single_pulse_trigger;
  logic [15:0] cal_count;
  logic [15:0] cal_width;
  logic [15:0] cal_period;
  logic [11:0] short_limit;
  logic [11:0] crank_reference_angle;
  logic [2:0]  seq_len;
  logic [2:0]  seq_waddr;
  logic [2:0]  irq_status;
  logic [2:0]  irq_mask;
  logic        critical_fault_clear;
  logic        module_enable_control;
  logic        open_fault_suppress;
  logic        edge_falling;
  logic [3:0]  invert;
  logic [1:0]  command_source_mode;
  // Synchronisers for pins
  logic [3:0]  din_s1, din_s2;
  logic        trg_s1, trg_s2, trg_d;
  logic        crk_s1, crk_s2, crk_d;
  logic        slot_s1, slot_s2, pwr_s1, pwr_s2;
  logic        present;
  // Timing
  logic [15:0] ms_div;
  logic        ms_tick;
  logic [15:0] cal_left, cal_time;
  logic        cal_on;
  logic        one_hot;
  logic [15:0] sp_left;
  logic [3:0]  sp_mask;
  icc_pkg::icc_seq_t seq_state;
  logic [2:0]  seq_idx;
  logic [31:0] seq_word;
  logic [15:0] seq_time;
  logic        seq_on;
  logic        trig_edge, crank_edge;
  logic        seq_done;
  logic [3:0]  src_cmd, next_cmd;
  logic [3:0]  shorts;
  logic [11:0] angle_target;
  logic        seq_wr;

  assign module_enable_control = control[icc_pkg::CTL_ENABLE_BIT];
  assign command_source_mode   = control[icc_pkg::CTL_MODE_LSB +: 2];
  assign edge_falling          = control[icc_pkg::CTL_EDGE_BIT];
  assign open_fault_suppress   = control[icc_pkg::CTL_OPEN_SUP_BIT];
  assign invert                = control[icc_pkg::CTL_INV_LSB +: 4];
  assign seq_wr = reg_wr && (reg_addr == icc_pkg::REG_SEQ_DATA);

  // Pin synchronisers, two stages each
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {din_s1, din_s2} <= 8'h00;
      {trg_s1, trg_s2, trg_d, crk_s1, crk_s2, crk_d} <= 6'h00;
      {slot_s1, slot_s2, pwr_s1, pwr_s2} <= 4'h0;
    end else begin
      din_s1  <= direct_in;
      din_s2  <= din_s1;
      trg_s1  <= train_trigger_in;
      trg_s2  <= trg_s1;
      trg_d   <= trg_s2;
      crk_s1  <= crank_event_in;
      crk_s2  <= crk_s1;
      crk_d   <= crk_s2;
      slot_s1 <= slot_occupied;
      slot_s2 <= slot_s1;
      pwr_s1  <= ext_power_ok;
      pwr_s2  <= pwr_s1;
    end
  end

  assign present    = module_enable_control && slot_s2 && pwr_s2; // (R1)
  assign trig_edge  = edge_falling ? (trg_d && !trg_s2) : (!trg_d && trg_s2); // (R8)
  assign crank_edge = !crk_d && crk_s2;

  // Register writes; strobe bits are self-clearing
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      control <= icc_pkg::CONTROL_RST;
      chan_enable <= icc_pkg::ALL_CH_OFF;
      single_pulse_duration <= icc_pkg::SP_TIME_RST;
      single_pulse_channel_select <= icc_pkg::SEL_DISABLED;
      single_pulse_trigger <= 1'b0;
      critical_fault_clear <= 1'b0;
      cal_count <= '0;
      cal_width <= '0;
      cal_period <= '0;
      short_limit <= '1;
      crank_reference_angle <= '0;
      seq_len <= '0;
      seq_waddr <= '0;
      irq_mask <= '0;
    end else begin
      single_pulse_trigger <= 1'b0; // (R11)
      critical_fault_clear <= 1'b0;
      if (seq_wr) begin
        seq_waddr <= seq_waddr + 3'd1;
      end
      if (reg_wr) begin
        case (reg_addr)
          icc_pkg::REG_CONTROL: begin
            control <= reg_wdata & 32'h0000_0F1F;
            critical_fault_clear <= reg_wdata[icc_pkg::CTL_CLEAR_BIT];
          end
          icc_pkg::REG_IRQ_MASK:    irq_mask <= reg_wdata[2:0];
          icc_pkg::REG_CH_ENABLE:   chan_enable <= reg_wdata[3:0];
          icc_pkg::REG_SP_CTRL: begin
            single_pulse_duration <= reg_wdata[15:0];
            single_pulse_channel_select <= reg_wdata[icc_pkg::SP_SEL_LSB +: 3];
            single_pulse_trigger <= reg_wdata[icc_pkg::SP_TRIG_BIT];
          end
          icc_pkg::REG_CAL_COUNT:   cal_count <= reg_wdata[15:0];
          icc_pkg::REG_CAL_WIDTH:   cal_width <= reg_wdata[15:0];
          icc_pkg::REG_CAL_PERIOD:  cal_period <= reg_wdata[15:0];
          icc_pkg::REG_SHORT_LIMIT: short_limit <= reg_wdata[11:0];
          icc_pkg::REG_CRANK_REF:   crank_reference_angle <= reg_wdata[11:0];
          icc_pkg::REG_SEQ_CTRL: begin
            seq_len <= reg_wdata[2:0];
            seq_waddr <= reg_wdata[10:8];
          end
          default: ;
        endcase
      end
    end
  end

  // Millisecond enable pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ms_div <= '0;
    end else if (ms_div == 16'(icc_pkg::MS_CYCLES - 1)) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + 16'd1;
    end
  end
  assign ms_tick = (ms_div == 16'(icc_pkg::MS_CYCLES - 1));

  // Calibration burst: count, width and period in milliseconds
  assign one_hot = (chan_enable != 4'h0) && ((chan_enable & (chan_enable - 4'd1)) == 4'h0);
  always_ff @(posedge core_clk) begin
    if (!rst_n || command_source_mode != icc_pkg::ICC_MODE_CAL || !present) begin
      cal_left <= '0;
      cal_time <= '0;
      cal_on <= 1'b0;
    end else if (cal_left == 16'h0 && cal_time == 16'h0 && !cal_on) begin
      cal_left <= cal_count; // Arm on entering the mode
      cal_time <= 16'hFFFF;
    end else if (ms_tick && cal_left != 16'h0) begin
      if (cal_time >= cal_period - 16'd1 || cal_time == 16'hFFFF) begin
        cal_time <= '0;
        cal_on <= (cal_width != 16'h0); // (R6)
      end else begin
        cal_time <= cal_time + 16'd1;
        if (cal_time + 16'd1 >= cal_width && cal_on) begin
          cal_on <= 1'b0;
          cal_left <= cal_left - 16'd1;
        end
      end
    end
  end

  // Pulse sequence for triggered and angle modes
  icc_seq_mem u_mem (
    .core_clk (core_clk),
    .wr_en    (seq_wr),
    .wr_addr  (seq_waddr),
    .wr_data  (reg_wdata),
    .rd_addr  (seq_idx),
    .rd_data  (seq_word)
  );
  // Word: [31:20] angle offset, [15:0] width in ms
  assign angle_target = crank_reference_angle + seq_word[31:20]; // (R9)
  always_ff @(posedge core_clk) begin
    if (!rst_n || !present || command_source_mode[1] == 1'b0) begin
      seq_state <= icc_pkg::ICC_SEQ_IDLE;
      seq_idx <= '0;
      seq_time <= '0;
      seq_done <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      case (seq_state)
        icc_pkg::ICC_SEQ_IDLE: begin
          seq_idx <= '0;
          if (command_source_mode == icc_pkg::ICC_MODE_ANGLE || trig_edge) begin
            seq_state <= icc_pkg::ICC_SEQ_WAIT; // (R8)
          end
        end
        icc_pkg::ICC_SEQ_WAIT: begin
          seq_time <= '0;
          if (command_source_mode == icc_pkg::ICC_MODE_TRAIN ||
              (crank_edge && crank_angle == angle_target)) begin
            seq_state <= icc_pkg::ICC_SEQ_PULSE; // (R9)
          end
        end
        icc_pkg::ICC_SEQ_PULSE: begin
          if (ms_tick) begin
            seq_time <= seq_time + 16'd1;
          end
          if (seq_time >= seq_word[15:0]) begin
            seq_state <= icc_pkg::ICC_SEQ_GAP;
          end
        end
        icc_pkg::ICC_SEQ_GAP: begin
          if (seq_idx >= seq_len) begin
            seq_state <= icc_pkg::ICC_SEQ_IDLE;
            seq_done <= 1'b1;
          end else begin
            seq_idx <= seq_idx + 3'd1;
            seq_state <= icc_pkg::ICC_SEQ_WAIT;
          end
        end
        default: seq_state <= icc_pkg::ICC_SEQ_IDLE;
      endcase
    end
  end
  assign seq_on = (seq_state == icc_pkg::ICC_SEQ_PULSE);

  // Single pulse: ms countdown on the selected channel
  always_ff @(posedge core_clk) begin
    if (!rst_n || !present) begin
      sp_left <= '0;
      sp_mask <= '0;
    end else if (single_pulse_trigger && single_pulse_channel_select != icc_pkg::SEL_DISABLED &&
                 single_pulse_channel_select <= 3'd4) begin // (R12)
      sp_left <= single_pulse_duration; // (R10)
      sp_mask <= 4'(4'h1 << (single_pulse_channel_select - 3'd1));
    end else if (ms_tick && sp_left != 16'h0) begin
      sp_left <= sp_left - 16'd1;
      if (sp_left == 16'd1) begin
        sp_mask <= '0;
      end
    end
  end

  // Mode source selection, one mode for all channels
  always_comb begin
    case (icc_pkg::icc_mode_t'(command_source_mode)) // (R3)
      icc_pkg::ICC_MODE_DIRECT: src_cmd = din_s2 ^ invert; // (R4) (R5)
      icc_pkg::ICC_MODE_CAL:    src_cmd = (one_hot && cal_on) ? chan_enable : 4'h0; // (R7)
      icc_pkg::ICC_MODE_TRAIN:  src_cmd = seq_on ? 4'hF : 4'h0;
      icc_pkg::ICC_MODE_ANGLE:  src_cmd = seq_on ? 4'hF : 4'h0;
      default:                  src_cmd = 4'h0;
    endcase
    next_cmd = present ? (((src_cmd & chan_enable) | sp_mask) & ~shorts) : 4'h0; // (R15) (R18)
  end

  // Short detectors, one per channel
  genvar g;
  generate
    for (g = 0; g < icc_pkg::NUM_CH; g++) begin : g_short
      icc_short_det u_det (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .sample_en  (current_valid && injector_cmd[g]),
        .current    (channel_current[g*12 +: 12]),
        .rate_limit (short_limit),
        .clear      (critical_fault_clear), // (R13)
        .short_flag (shorts[g])
      );
    end
  endgenerate

  // Registered outputs and open indicators at each pulse end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      injector_cmd <= '0;
      short_circuit_flags <= '0;
      open_fault_flags <= '0;
      module_present_flag <= 1'b0;
      module_link_en <= 1'b0;
    end else begin
      injector_cmd <= next_cmd;
      short_circuit_flags <= shorts;
      module_present_flag <= present;
      module_link_en <= present; // (R2)
      for (int i = 0; i < 4; i++) begin
        if (open_fault_suppress) begin
          open_fault_flags[i] <= 1'b0; // (R16)
        end else if (injector_cmd[i] && !next_cmd[i]) begin
          open_fault_flags[i] <= !reached_open_level[i]; // (R17)
        end
      end
    end
  end

  // Sticky events; set wins over read clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= ((reg_rd && reg_addr == icc_pkg::REG_IRQ_STATUS) ? 3'h0 : irq_status)
                  | {seq_done, |(injector_cmd & ~next_cmd & ~reached_open_level) &
                     !open_fault_suppress, |(shorts & ~short_circuit_flags)};
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        icc_pkg::REG_CONTROL:     reg_rdata <= control;
        icc_pkg::REG_STATUS:      reg_rdata <= {16'h0, open_fault_flags, shorts,
                                                injector_cmd, 3'h0, present};
        icc_pkg::REG_IRQ_STATUS:  reg_rdata <= {29'h0, irq_status};
        icc_pkg::REG_IRQ_MASK:    reg_rdata <= {29'h0, irq_mask};
        icc_pkg::REG_CH_ENABLE:   reg_rdata <= {28'h0, chan_enable};
        icc_pkg::REG_SP_CTRL:     reg_rdata <= {13'h0, single_pulse_channel_select,
                                                single_pulse_duration};
        icc_pkg::REG_CAL_COUNT:   reg_rdata <= {16'h0, cal_count};
        icc_pkg::REG_CAL_WIDTH:   reg_rdata <= {16'h0, cal_width};
        icc_pkg::REG_CAL_PERIOD:  reg_rdata <= {16'h0, cal_period};
        icc_pkg::REG_SHORT_LIMIT: reg_rdata <= {20'h0, short_limit};
        icc_pkg::REG_CRANK_REF:   reg_rdata <= {20'h0, crank_reference_angle};
        icc_pkg::REG_SEQ_CTRL:    reg_rdata <= {21'h0, seq_waddr, 5'h0, seq_len};
        default:                  reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

//--- tb/icc_checker.sv
// Port-level assertions for the injector command block
`timescale 1ns/10ps
module icc_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        slot_occupied,
  input wire logic        ext_power_ok,
  input wire logic        current_valid,
  input wire logic [3:0]  injector_cmd,
  input wire logic [3:0]  short_circuit_flags,
  input wire logic [3:0]  open_fault_flags,
  input wire logic        module_present_flag
);
  logic clr_wr;
  logic sup_q;
  // Fault clear strobe seen on the register port
  assign clr_wr = reg_wr && reg_addr == icc_pkg::REG_CONTROL
    && reg_wdata[icc_pkg::CTL_CLEAR_BIT];
  // Open suppress setting mirrored from control writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sup_q <= 1'b0;
    end else if (reg_wr && reg_addr == icc_pkg::REG_CONTROL) begin
      sup_q <= reg_wdata[icc_pkg::CTL_OPEN_SUP_BIT];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Clear strobe followed by quiet current sensing
  sequence s_quiet_clear;
    clr_wr && !current_valid ##1 !current_valid [*3];
  endsequence
  chk_present_slot: assert property (
    !slot_occupied [*4] |=> !module_present_flag) else $error("present with no slot");
  chk_present_power: assert property (
    !ext_power_ok [*4] |=> !module_present_flag) else $error("present with no power");
  chk_short_holds: assert property (
    |(~short_circuit_flags & $past(short_circuit_flags))
    |-> $past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3))
    else $error("short flag dropped without clear");
  chk_short_off: assert property (
    (short_circuit_flags & $past(short_circuit_flags)
    & $past(short_circuit_flags, 2) & injector_cmd) == 4'h0)
    else $error("shorted channel still driven");
  chk_clear_all: assert property (
    s_quiet_clear |-> short_circuit_flags == 4'h0) else $error("flags survive clear");
  chk_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("read data outside slot");
  chk_open_sup: assert property (
    sup_q && $past(sup_q) && $past(sup_q, 2) |-> open_fault_flags == 4'h0)
    else $error("open flag while suppressed");
  chk_open_at_end: assert property (
    $rose(open_fault_flags[0]) |-> $past(injector_cmd[0]) || $past(injector_cmd[0], 2))
    else $error("open flag not at pulse end");
endmodule
bind icc_top icc_checker chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .slot_occupied, .ext_power_ok, .current_valid, .injector_cmd,
  .short_circuit_flags, .open_fault_flags, .module_present_flag);

//--- tb/icc_far_model.sv
// Current sense and open level model for the injector channels
`timescale 1ns/10ps
module icc_far_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  injector_cmd,
  input  wire logic [3:0]  short_mask,
  input  wire logic [3:0]  open_mask,
  output logic             current_valid,
  output logic      [47:0] channel_current,
  output logic      [3:0]  reached_open_level
);
  logic [2:0] div;
  // Samples every eight cycles, steep rise on shorted channels
  always_ff @(posedge core_clk) begin
    div <= rst_n ? div + 3'h1 : 3'h0;
    current_valid <= rst_n && div == 3'h7 && |injector_cmd;
    for (int i = 0; i < 4; i++) begin
      if (!rst_n || !injector_cmd[i]) begin
        channel_current[i*12 +: 12] <= 12'h000;
      end else if (div == 3'h7 && channel_current[i*12 +: 12] < 12'hE00) begin
        channel_current[i*12 +: 12] <= channel_current[i*12 +: 12]
          + (short_mask[i] ? 12'h200 : 12'h004);
      end
    end
  end
  // Open channels never reach the threshold
  assign reached_open_level = injector_cmd & ~open_mask;
endmodule

//--- tb/icc_top_tb.sv
// Self-checking bench for the injector command block
`timescale 1ns/10ps
module icc_top_tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        slot_occupied = 1'b1;
  logic        ext_power_ok = 1'b1;
  logic [3:0]  direct_in = 4'h0;
  logic        train_trigger_in = 1'b0;
  logic        crank_event_in = 1'b0;
  logic [11:0] crank_angle = 12'h000;
  logic [3:0]  short_mask = 4'h0;
  logic [3:0]  open_mask = 4'h0;
  logic [31:0] reg_rdata;
  logic        current_valid;
  logic [47:0] channel_current;
  logic [3:0]  reached_open_level, injector_cmd, short_circuit_flags, open_fault_flags;
  logic        module_present_flag, module_link_en, irq;
  logic [3:0]  d;
  logic [63:0] ent;
  logic [63:0] exp_q[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          seed = 18259;

  always #12.5 core_clk = ~core_clk;

  icc_top dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .slot_occupied, .ext_power_ok, .direct_in, .train_trigger_in, .crank_event_in,
    .crank_angle, .current_valid, .channel_current, .reached_open_level, .injector_cmd,
    .short_circuit_flags, .open_fault_flags, .module_present_flag, .module_link_en, .irq);
  icc_far_model far_u (.core_clk, .rst_n, .injector_cmd, .short_mask, .open_mask,
    .current_valid, .channel_current, .reached_open_level);

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] md, logic [3:0] inv, logic sup, logic clr);
    return {20'h0_0000, inv, 2'b00, clr, sup, 1'b0, md, 1'b1};
  endfunction

  // Compares each read answer with the oldest note
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      ent = exp_q.pop_front();
      check("reg_rdata", reg_rdata & ent[63:32], ent[31:0]);
    end
  end

  // Main sequence
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    rd(icc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    wr(icc_pkg::REG_CONTROL, ctl(2'b00, 4'h0, 1'b0, 1'b0));
    cyc(6);
    rd(icc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    slot_occupied <= 1'b0;
    ext_power_ok <= 1'b0;
    cyc(6);
    rd(icc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
    slot_occupied <= 1'b1;
    ext_power_ok <= 1'b1;
    for (int i = 0; i < 20 && module_present_flag !== 1'b1; i++) cyc(1);
    check("module_link_en", 32'(module_link_en), 32'h0000_0001);
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(icc_pkg::REG_CH_ENABLE, 32'h0000_000F);
    wr(icc_pkg::REG_SHORT_LIMIT, 32'h0000_0100);
    wr(icc_pkg::REG_IRQ_MASK, 32'h0000_0000);
    // Direct mode with random inputs, plain then inverted
    for (int i = 0; i < 4; i++) begin
      d = 4'($random(seed));
      direct_in <= d;
      wr(icc_pkg::REG_CONTROL, ctl(2'b00, {4{i[0]}}, 1'b0, 1'b0));
      cyc(4);
      rd(icc_pkg::REG_STATUS, 32'h0000_00F0, {24'h0, d ^ {4{i[0]}}, 4'h0});
    end
    wr(icc_pkg::REG_SEQ_DATA, 32'h0000_0000);
    train_trigger_in <= 1'b1;
    wr(icc_pkg::REG_CONTROL, ctl(2'b10, 4'h0, 1'b0, 1'b0));
    cyc(6);
    wr(icc_pkg::REG_CONTROL, ctl(2'b00, 4'h0, 1'b0, 1'b0));
    // Short on channel 0 while channel 1 runs on
    short_mask <= 4'h1;
    direct_in <= 4'h3;
    cyc(40);
    rd(icc_pkg::REG_STATUS, 32'h0000_0FF0, 32'h0000_0120);
    check("irq", {31'h0, irq}, 32'h0000_0000);
    short_mask <= 4'h0;
    cyc(40);
    rd(icc_pkg::REG_STATUS, 32'h0000_0FF0, 32'h0000_0120);
    wr(icc_pkg::REG_IRQ_MASK, 32'h0000_0001);
    cyc(2);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    rd(icc_pkg::REG_IRQ_STATUS, 32'h0000_0005, 32'h0000_0005);
    rd(icc_pkg::REG_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
    direct_in <= 4'h0;
    cyc(8);
    wr(icc_pkg::REG_CONTROL, ctl(2'b00, 4'h0, 1'b0, 1'b1));
    cyc(4);
    rd(icc_pkg::REG_STATUS, 32'h0000_0F00, 32'h0000_0000);
    // Open channel pulse, shown then suppressed
    open_mask <= 4'h1;
    for (int i = 0; i < 2; i++) begin
      wr(icc_pkg::REG_CONTROL, ctl(2'b00, 4'h0, i[0], 1'b0));
      direct_in <= 4'h1;
      cyc(6);
      rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0010);
      direct_in <= 4'h0;
      cyc(6);
      rd(icc_pkg::REG_STATUS, 32'h0000_F000, {16'h0, 3'h0, ~i[0], 12'h0});
    end
    open_mask <= 4'h0;
    // Calibration, all enabled: silent
    wr(icc_pkg::REG_CAL_COUNT, 32'h0000_0001);
    wr(icc_pkg::REG_CAL_WIDTH, 32'h0000_0004);
    wr(icc_pkg::REG_CONTROL, ctl(2'b01, 4'h0, 1'b0, 1'b0));
    cyc(8);
    rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0000);
    // Single pulse: disabled select, then select 2 (channel 1) for 2 ms
    wr(icc_pkg::REG_SP_CTRL, 32'h8000_0002);
    cyc(4);
    rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0000);
    wr(icc_pkg::REG_SP_CTRL, 32'h8002_0002);
    cyc(2);
    rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0020);
    rd(icc_pkg::REG_SP_CTRL, 32'h8007_FFFF, 32'h0002_0002);
    cyc(39000);
    rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0020);
    cyc(41100);
    rd(icc_pkg::REG_STATUS, 32'h0000_00F0, 32'h0000_0000);
    cyc(2);
    stop_test();
  end

  // Cuts a hung run short
  initial begin
    #(95000 * 25);
    n_fail++;
    stop_test();
  end
endmodule
